// File: design/pcd_defines.svh
// register offsets, reset values and field positions for the paged divider block
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH
`define PCD_BANK_ADDR 8'h7F
`define PCD_LOWER_LAST 8'h7E
`define PCD_UPPER_FIRST 8'h80
`define PCD_UPPER_LAST 8'hFB
`define PCD_RATIO_A_ADDR 8'h80
`define PCD_RATIO_B_ADDR 8'h83
`define PCD_RATIO_C_ADDR 8'h86
`define PCD_BANK_RESET 8'h00
`define PCD_RATIO_AB_RESET 24'h000002
`define PCD_RATIO_C_RESET 24'h000040
`define PCD_BANK_BIT 0
`define PCD_RATIO_MSB 22
`endif

// File: design/pcd_pkg.sv
// types shared by the paged divider block
package pcd_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } pcd_host_req_t;
    typedef struct packed {
        logic [22:0] divide_value_a;
        logic [22:0] divide_value_b;
    } pcd_ratio_t;
endpackage

// File: design/pcd_post_divider.sv
// programmable clock divider driven by the synthesizer clock enable
`timescale 1ns/1ps
`include "pcd_defines.svh"
module pcd_post_divider #(
    parameter int WIDTH = 23
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // synthesizer tick and ratio
    input wire logic synth_tick,
    input wire logic [WIDTH-1:0] ratio,
    // divided output
    output logic div_out
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] half;
    assign half = ratio >> 1;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            div_out <= 1'b0;
        end else if (synth_tick) begin
            if (ratio < WIDTH'(2) || count_reg >= ratio - WIDTH'(1)) begin
                count_reg <= '0;
                div_out <= 1'b1;
            end else begin
                count_reg <= count_reg + WIDTH'(1);
                if (count_reg + WIDTH'(1) == half) begin
                    div_out <= 1'b0;
                end
            end
        end
    end
endmodule

// File: design/pcd_paged_config.sv
// paged register map with post divider ratio registers
//
// Summary of operation
// - with the bank bit clear host addresses reach internal 0x00 to 0x7E.
// - with the bank bit set host addresses reach internal 0x80 to 0xFE.
// - the bank bit supplies internal address bit seven for every access except host address 0x7F.
// - bits 22:0 of ratio A divide the synthesizer clock for output A.
// - bits 22:0 of ratio B divide the synthesizer clock for output B.
// - ratios A and B reset to 2, each over three byte addresses.
// - ratio C sits at 0x86 to 0x88 and resets to 0x000040.
`timescale 1ns/1ps
`include "pcd_defines.svh"
module pcd_paged_config (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // host register port
    input wire pcd_pkg::pcd_host_req_t host_req,
    output logic [7:0] host_rdata,
    // synthesizer tick in, divided clocks, bank select and ratio fields out
    input wire logic synth_tick,
    output logic div_out_a,
    output logic div_out_b,
    output logic bank_sel,
    output pcd_pkg::pcd_ratio_t ratios
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] bank_reg;
    logic [23:0] ratio_a_reg;
    logic [23:0] ratio_b_reg;
    logic [23:0] ratio_c_reg;
    logic [7:0] int_addr;

    function automatic logic [7:0] map_addr(input logic [6:0] a,
                                            input logic bank);
        if (a == 7'h7F) begin
            map_addr = `PCD_BANK_ADDR;
        end else begin
            map_addr = {bank, a};
        end
    endfunction

    assign int_addr = map_addr(host_req.addr, bank_reg[`PCD_BANK_BIT]);
    assign bank_sel = bank_reg[`PCD_BANK_BIT];

    function automatic logic in_ratio(input logic [7:0] a,
                                      input logic [7:0] base);
        in_ratio = (a >= base) && (a <= base + 8'h02);
    endfunction

    // ----------------------------------------
    // write path
    // ----------------------------------------
    // byte registers with reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bank_reg <= `PCD_BANK_RESET;
            ratio_a_reg <= `PCD_RATIO_AB_RESET;
            ratio_b_reg <= `PCD_RATIO_AB_RESET;
            ratio_c_reg <= `PCD_RATIO_C_RESET;
        end else if (host_req.wr) begin
            if (int_addr == `PCD_BANK_ADDR) begin
                bank_reg <= {7'h00, host_req.wdata[`PCD_BANK_BIT]};
            end else if (in_ratio(int_addr, `PCD_RATIO_A_ADDR)) begin
                ratio_a_reg[8*(2-(int_addr-`PCD_RATIO_A_ADDR)) +: 8]
                    <= host_req.wdata;
            end else if (in_ratio(int_addr, `PCD_RATIO_B_ADDR)) begin
                ratio_b_reg[8*(2-(int_addr-`PCD_RATIO_B_ADDR)) +: 8]
                    <= host_req.wdata;
            end else if (in_ratio(int_addr, `PCD_RATIO_C_ADDR)) begin
                ratio_c_reg[8*(2-(int_addr-`PCD_RATIO_C_ADDR)) +: 8]
                    <= host_req.wdata;
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // page routing on read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            host_rdata <= 8'h00;
        end else if (host_req.rd) begin
            if (int_addr == `PCD_BANK_ADDR) begin
                host_rdata <= bank_reg;
            end else if (in_ratio(int_addr, `PCD_RATIO_A_ADDR)) begin
                host_rdata <=
                    ratio_a_reg[8*(2-(int_addr-`PCD_RATIO_A_ADDR)) +: 8];
            end else if (in_ratio(int_addr, `PCD_RATIO_B_ADDR)) begin
                host_rdata <=
                    ratio_b_reg[8*(2-(int_addr-`PCD_RATIO_B_ADDR)) +: 8];
            end else if (in_ratio(int_addr, `PCD_RATIO_C_ADDR)) begin
                host_rdata <=
                    ratio_c_reg[8*(2-(int_addr-`PCD_RATIO_C_ADDR)) +: 8];
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // dividers
    // ----------------------------------------
    // ratio A and B fields feed dividers
    assign ratios = {ratio_a_reg[`PCD_RATIO_MSB:0],
                     ratio_b_reg[`PCD_RATIO_MSB:0]};

    pcd_post_divider #(.WIDTH(23)) u_div_a (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .synth_tick(synth_tick),
        .ratio(ratio_a_reg[`PCD_RATIO_MSB:0]),
        .div_out(div_out_a)
    );

    pcd_post_divider #(.WIDTH(23)) u_div_b (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .synth_tick(synth_tick),
        .ratio(ratio_b_reg[`PCD_RATIO_MSB:0]),
        .div_out(div_out_b)
    );

    // ----------------------------------------
    // assertion helpers
    // ----------------------------------------
    logic addr_hit;
    assign addr_hit = (int_addr == `PCD_BANK_ADDR)
        || in_ratio(int_addr, `PCD_RATIO_A_ADDR)
        || in_ratio(int_addr, `PCD_RATIO_B_ADDR)
        || in_ratio(int_addr, `PCD_RATIO_C_ADDR);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_bank_always_seen: assert property (
        host_req.addr == 7'h7F |-> int_addr == `PCD_BANK_ADDR)
        else $error("bank register not reachable");
    a_lower_page_map: assert property (
        !bank_sel && host_req.addr != 7'h7F |-> int_addr <= `PCD_LOWER_LAST)
        else $error("lower page mapping wrong");
    a_upper_page_map: assert property (
        bank_sel |-> int_addr >= `PCD_UPPER_FIRST
            || int_addr == `PCD_BANK_ADDR)
        else $error("upper page mapping wrong");
    a_top_bit_bank: assert property (
        host_req.addr != 7'h7F |-> int_addr[7] == bank_sel)
        else $error("top address bit not from bank");
    a_bank_write_takes: assert property (
        host_req.wr && host_req.addr == 7'h7F
        |=> bank_sel == $past(host_req.wdata[0]))
        else $error("bank write lost");
    a_ratio_a_write: assert property (
        host_req.wr && int_addr == 8'h82
        |=> ratios.divide_value_a[7:0] == $past(host_req.wdata))
        else $error("ratio a low byte write lost");
    a_ratio_b_write: assert property (
        host_req.wr && int_addr == 8'h85
        |=> ratios.divide_value_b[7:0] == $past(host_req.wdata))
        else $error("ratio b low byte write lost");
    a_ratio_c_read: assert property (
        host_req.rd && int_addr == 8'h88
        |=> host_rdata == $past(ratio_c_reg[7:0]))
        else $error("ratio c read wrong");
    a_stable_no_write: assert property (
        !host_req.wr |=> $stable(ratio_a_reg) && $stable(ratio_b_reg))
        else $error("ratio changed without write");

    a_unmapped_read_zero: assert property (
        host_req.rd && !addr_hit |=> host_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_lower_no_ratio: assert property (
        host_req.wr && !bank_sel && host_req.addr != 7'h7F
        |=> $stable(ratio_a_reg) && $stable(ratio_b_reg)
            && $stable(ratio_c_reg))
        else $error("lower page write reached a ratio");
    a_upper_page_limit: assert property (
        bank_sel && host_req.addr <= 7'h7B |-> int_addr >= `PCD_UPPER_FIRST
            && int_addr <= `PCD_UPPER_LAST)
        else $error("upper page address out of range");
    a_bank_read_back: assert property (
        host_req.rd && host_req.addr == 7'h7F
        |=> host_rdata == {7'h00, $past(bank_sel)})
        else $error("bank register read wrong");
    a_bank_one_bit: assert property (
        bank_reg[7:1] == 7'h00)
        else $error("bank register upper bits set");
    a_ratio_a_read: assert property (
        host_req.rd && int_addr == 8'h81
        |=> host_rdata == $past(ratio_a_reg[15:8]))
        else $error("ratio a middle byte read wrong");
    a_ratio_b_read: assert property (
        host_req.rd && int_addr == 8'h83
        |=> host_rdata == $past(ratio_b_reg[23:16]))
        else $error("ratio b top byte read wrong");
    a_ratio_c_write: assert property (
        host_req.wr && int_addr == 8'h86
        |=> ratio_c_reg[23:16] == $past(host_req.wdata))
        else $error("ratio c top byte write lost");
    a_ratio_c_hold: assert property (
        !host_req.wr |=> $stable(ratio_c_reg))
        else $error("ratio c changed without write");
    a_rdata_hold: assert property (
        !host_req.rd |=> $stable(host_rdata))
        else $error("read data moved without read");
    a_div_a_tick: assert property (
        $rose(div_out_a) |-> $past(synth_tick))
        else $error("divider a moved without tick");
    a_div_b_tick: assert property (
        $rose(div_out_b) |-> $past(synth_tick))
        else $error("divider b moved without tick");

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    c_page_switch: cover property (host_req.wr && host_req.addr == 7'h7F
        && host_req.wdata[0]);
    c_ratio_a_write: cover property (host_req.wr && int_addr == 8'h80);
    c_ratio_c_read: cover property (host_req.rd && int_addr == 8'h86);
    c_div_a_edge: cover property ($rose(div_out_a));
    c_lower_write: cover property (host_req.wr && !bank_sel
        && host_req.addr != 7'h7F);
endmodule

// File: sim/pcd_host_model.sv
// host controller model issuing byte accesses to the paged register port
`timescale 1ns/1ps
module pcd_host_model (
    // clock
    input wire logic ref_clk,
    // host register port
    output pcd_pkg::pcd_host_req_t host_req,
    input wire logic [7:0] host_rdata
);
    initial host_req = '0;

    // one byte access, released address and data lines carry inverted values
    task automatic access(input logic w, input logic [6:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        host_req <= {w, ~w, a, d};
        @(posedge ref_clk);
        host_req <= {2'b00, ~a, ~d};
        @(posedge ref_clk);
        q = host_rdata;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00, q);
    endtask

    task automatic set_bank(input logic b);
        logic [7:0] q;
        access(1'b1, 7'h7F, {7'h00, b}, q);
    endtask

    task automatic wr_ratio(input logic [6:0] a, input logic [23:0] v);
        logic [7:0] q;
        logic [23:0] w;
        w = v & 24'h7FFFFF;
        access(1'b1, a, w[23:16], q);
        access(1'b1, a + 7'h01, w[15:8], q);
        access(1'b1, a + 7'h02, w[7:0], q);
    endtask
endmodule

// File: sim/pcd_paged_config_bench.sv
// self-checking bench for the paged divider register block
`timescale 1ns/1ps
module pcd_paged_config_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic synth_tick = 1'b1;
    pcd_pkg::pcd_host_req_t host_req;
    logic [7:0] host_rdata;
    logic div_out_a;
    logic div_out_b;
    logic bank_sel;
    pcd_pkg::pcd_ratio_t ratios;
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] q;
    logic [7:0] dflt [9] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02,
                             8'h00, 8'h00, 8'h40};

    pcd_paged_config dut (.ref_clk(ref_clk), .rstn(rstn),
        .host_req(host_req), .host_rdata(host_rdata),
        .synth_tick(synth_tick), .div_out_a(div_out_a),
        .div_out_b(div_out_b), .bank_sel(bank_sel), .ratios(ratios));
    pcd_host_model host (.ref_clk(ref_clk), .host_req(host_req),
        .host_rdata(host_rdata));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host.rd(a, q);
        chk({40'h0, q}, {40'h0, exp});
    endtask

    // cycles between two rising edges of one divided output
    task automatic period(input logic b, input logic slow, input int exp);
        int r0;
        int r1;
        logic p;
        logic c;
        r0 = -1;
        r1 = -1;
        p = 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk);
            synth_tick <= slow ? ~synth_tick : 1'b1;
            @(negedge ref_clk);
            c = b ? div_out_b : div_out_a;
            if (c === 1'b1 && p === 1'b0) begin
                if (r0 < 0) r0 = i;
                else if (r1 < 0) r1 = i;
            end
            p = c;
        end
        @(posedge ref_clk);
        synth_tick <= 1'b1;
        chk(48'(r1 - r0), 48'(exp));
    endtask

    task automatic t_reset();
        rd_chk(7'h7F, 8'h00);
        chk({47'h0, bank_sel}, 48'h0);
        chk({2'b00, ratios}, {2'b00, 23'h2, 23'h2});
        host.set_bank(1'b1);
        chk({47'h0, bank_sel}, 48'h1);
        for (int i = 0; i < 9; i++) begin
            rd_chk(7'(i), dflt[i]);
        end
    endtask

    task automatic t_ratio();
        host.wr_ratio(7'h00, 24'h800003);
        host.wr_ratio(7'h03, 24'h000004);
        chk({2'b00, ratios}, {2'b00, 23'h3, 23'h4});
        rd_chk(7'h00, 8'h00);
        rd_chk(7'h05, 8'h04);
        period(1'b0, 1'b0, 3);
        period(1'b1, 1'b0, 4);
        period(1'b0, 1'b1, 6);
    endtask

    task automatic t_page();
        host.wr_ratio(7'h06, 24'h123456);
        rd_chk(7'h06, 8'h12);
        host.set_bank(1'b0);
        rd_chk(7'h06, 8'h00);
        host.wr_ratio(7'h00, 24'h7FFFFF);
        rd_chk(7'h7F, 8'h00);
        host.set_bank(1'b1);
        rd_chk(7'h7F, 8'h01);
        rd_chk(7'h08, 8'h56);
        chk({2'b00, ratios}, {2'b00, 23'h3, 23'h4});
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_ratio();
        t_page();
        wrap_up();
    end

    initial begin
        #(100 * 3000);
        n_fail++;
        wrap_up();
    end
endmodule
